// [include/spt_pkg.sv]
// Constants shared by the speed pot and thermistor trip block
package spt_pkg;
   localparam int NUM_INPUTS = 6;
   localparam int FUNC_W = 5;
   localparam int FREQ_W = 16;
   localparam int TIME_W = 16;
   // Input function codes
   localparam logic [4:0] FUNC_THERM = 5'h13;
   localparam logic [4:0] FUNC_RAISE = 5'h1B;
   localparam logic [4:0] FUNC_LOWER = 5'h1C;
   localparam int THERM_INPUT_IDX = 4;
   // Frequency command source value for operator control
   localparam logic [1:0] SRC_OPERATOR = 2'h2;
   // Trip code reported on thermistor trip
   localparam logic [7:0] TRIP_CODE_THERM = 8'h35;
   localparam logic [7:0] TRIP_CODE_NONE = 8'h00;
   // Thermistor threshold in ohms
   localparam logic [15:0] THERM_TRIP_OHMS = 16'h0BB8;
   localparam logic [15:0] THERM_OPEN_OHMS = 16'hFFFF;
   localparam int CLK_HZ = 50_000_000;
   localparam int RESET_MIN_MS = 12;
   localparam int RAMP_TICK_US = 100;
   localparam int RAMP_TICK_CYC = CLK_HZ / 1_000_000 * RAMP_TICK_US;
   localparam logic [FREQ_W-1:0] FREQ_RESET = 16'h0000;
   typedef enum logic [1:0] {
      SPT_IDLE = 2'b00,
      SPT_RAISE = 2'b01,
      SPT_LOWER = 2'b10,
      SPT_TRIP = 2'b11
   } spt_state_t;
endpackage

// [core/spt_ramp_tick.sv]
// Divider producing the ramp step enable
module spt_ramp_tick #(
   parameter int DIV = spt_pkg::RAMP_TICK_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Enable out
   output logic tick
);
   logic [15:0] cnt_q, cnt_d;
   logic tick_q, tick_d;

   always_comb begin
      tick_d = 1'b0;
      cnt_d = cnt_q + 16'h0001;
      if (cnt_q == 16'(DIV - 1)) begin
         cnt_d = 16'h0000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule // spt_ramp_tick

// [core/spt_speed_pot.sv]
// Motorized speed pot and thermistor trip monitor
// Overview of operation
// - Resistance above threshold trips, output off, code
// - Open thermistor also forces trip
// - Thermistor function code 19, fifth input only
// - Raise code 27, lower code 28, any input
// - Raise held ramps frequency up from present
// - Lower held ramps frequency down from present
// - Release freezes frequency where reached
// - Ramps use first or second accel/decel set
// - Adjust only with operator frequency source
// - Adjust ignored while jog in use
// - Frequency limited zero to maximum
// - Adjustment starts from standard frequency setting
// - Adjust only under active run command
// - Reset pulse cancels trip state
module spt_speed_pot #(
   parameter int NUM_INPUTS = spt_pkg::NUM_INPUTS,
   parameter int FREQ_W = spt_pkg::FREQ_W,
   parameter int TIME_W = spt_pkg::TIME_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Programmable inputs and their function codes
   input wire logic [NUM_INPUTS-1:0] prog_inputs,
   input wire logic [NUM_INPUTS*spt_pkg::FUNC_W-1:0] input_func,
   // Thermistor measurement in ohms
   input wire logic [15:0] thermistor_sense_input,
   // Drive control
   input wire logic run_cmd,
   input wire logic jog_input,
   input wire logic trip_reset_input,
   input wire logic [1:0] freq_source,
   input wire logic second_set_sel,
   // Frequency settings
   input wire logic [FREQ_W-1:0] std_freq_setting,
   input wire logic [FREQ_W-1:0] max_freq,
   // Ramp times in ramp ticks per frequency step, less one (zero steps on every tick)
   input wire logic [TIME_W-1:0] first_accel_time,
   input wire logic [TIME_W-1:0] first_decel_time,
   input wire logic [TIME_W-1:0] second_accel_time,
   input wire logic [TIME_W-1:0] second_decel_time,
   // Outputs
   output logic [FREQ_W-1:0] out_freq,
   output logic motor_enable,
   output logic trip_active,
   output logic [7:0] trip_code,
   output logic ramping
);
   // Decode: is any input assigned code active, honoring where code is legal
   function automatic logic func_hit(input logic [NUM_INPUTS*spt_pkg::FUNC_W-1:0] f,
                                     input logic [NUM_INPUTS-1:0] pins,
                                     input logic [4:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_INPUTS; i++) begin
         if (f[i*spt_pkg::FUNC_W +: spt_pkg::FUNC_W] == code) begin
            if (code != spt_pkg::FUNC_THERM || i == spt_pkg::THERM_INPUT_IDX) begin
               hit = hit | pins[i];
            end
         end
      end
      return hit;
   endfunction

   // Raise or lower state, the two states in which frequency moves
   function automatic logic ramp_state(input spt_pkg::spt_state_t s);
      return (s == spt_pkg::SPT_RAISE) || (s == spt_pkg::SPT_LOWER);
   endfunction

   // One frequency step is due once the ramp count reaches its limit
   function automatic logic step_due(input logic [TIME_W-1:0] cnt,
                                     input logic [TIME_W-1:0] limit);
      return cnt >= limit;
   endfunction

   logic tick;
   logic raise_w, lower_w, therm_en, therm_fault, adjust_ok;
   logic [TIME_W-1:0] acc_t, dec_t;
   logic rst_in_q, rst_in_d;
   logic run_q, run_d;
   spt_pkg::spt_state_t st_q, st_d;
   logic [FREQ_W-1:0] freq_q, freq_d;
   logic [TIME_W-1:0] rcnt_q, rcnt_d;
   logic mot_q, mot_d;
   logic [7:0] code_q, code_d;
   logic trip_q, trip_d;
   logic ramp_q, ramp_d;

   spt_ramp_tick u_tick (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   assign raise_w = func_hit(input_func, prog_inputs, spt_pkg::FUNC_RAISE);
   assign lower_w = func_hit(input_func, prog_inputs, spt_pkg::FUNC_LOWER);
   // Thermistor only honoured on the fifth input
   assign therm_en = input_func[spt_pkg::THERM_INPUT_IDX*spt_pkg::FUNC_W +: spt_pkg::FUNC_W]
                     == spt_pkg::FUNC_THERM;
   assign therm_fault = therm_en && (thermistor_sense_input > spt_pkg::THERM_TRIP_OHMS
                        || thermistor_sense_input == spt_pkg::THERM_OPEN_OHMS);
   assign adjust_ok = run_cmd && !jog_input
                      && freq_source == spt_pkg::SRC_OPERATOR;
   assign acc_t = second_set_sel ? second_accel_time : first_accel_time;
   assign dec_t = second_set_sel ? second_decel_time : first_decel_time;

   // Edge detectors for the reset contact and the run command
   always_comb begin
      rst_in_d = trip_reset_input;
      run_d = run_cmd;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_in_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         rst_in_q <= rst_in_d;
         run_q <= run_d;
      end
   end

   // Trip, ramp state and output frequency
   always_comb begin
      st_d = st_q;
      freq_d = freq_q;
      rcnt_d = rcnt_q;
      mot_d = mot_q;
      code_d = code_q;
      if (therm_fault && st_q != spt_pkg::SPT_TRIP) begin
         st_d = spt_pkg::SPT_TRIP;
         mot_d = 1'b0;
         code_d = spt_pkg::TRIP_CODE_THERM;
      end else begin
         case (st_q)
            spt_pkg::SPT_TRIP: begin
               mot_d = 1'b0;
               // Clear on falling edge of reset pulse
               if (rst_in_q && !trip_reset_input && !therm_fault) begin
                  st_d = spt_pkg::SPT_IDLE;
                  code_d = spt_pkg::TRIP_CODE_NONE;
                  freq_d = std_freq_setting;
               end
            end
            default: begin
               mot_d = run_cmd;
               // New run starts from the standard setting
               if (run_cmd && !run_q) begin
                  freq_d = std_freq_setting;
               end
               st_d = spt_pkg::SPT_IDLE;
               if (adjust_ok && raise_w && !lower_w) begin
                  st_d = spt_pkg::SPT_RAISE;
               end else if (adjust_ok && lower_w && !raise_w) begin
                  st_d = spt_pkg::SPT_LOWER;
               end
               if (st_d != st_q) begin
                  rcnt_d = '0;
               end else if (tick && ramp_state(st_q)) begin
                  rcnt_d = rcnt_q + 1'b1;
                  if (st_q == spt_pkg::SPT_RAISE && step_due(rcnt_q, acc_t)) begin
                     rcnt_d = '0;
                     if (freq_q < max_freq) begin
                        freq_d = freq_q + 1'b1;
                     end
                  end
                  if (st_q == spt_pkg::SPT_LOWER && step_due(rcnt_q, dec_t)) begin
                     rcnt_d = '0;
                     if (freq_q != '0) begin
                        freq_d = freq_q - 1'b1;
                     end
                  end
               end
            end
         endcase
      end
      // Clamp also covers the reload after a trip clears
      if (freq_d > max_freq) begin
         freq_d = max_freq;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= spt_pkg::SPT_IDLE;
         freq_q <= spt_pkg::FREQ_RESET;
         rcnt_q <= '0;
         mot_q <= 1'b0;
         code_q <= spt_pkg::TRIP_CODE_NONE;
      end else begin
         st_q <= st_d;
         freq_q <= freq_d;
         rcnt_q <= rcnt_d;
         mot_q <= mot_d;
         code_q <= code_d;
      end
   end

   // Status flags kept in flops so no output is decoded
   always_comb begin
      trip_d = (st_d == spt_pkg::SPT_TRIP);
      ramp_d = ramp_state(st_d);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trip_q <= 1'b0;
         ramp_q <= 1'b0;
      end else begin
         trip_q <= trip_d;
         ramp_q <= ramp_d;
      end
   end

   assign out_freq = freq_q;
   assign motor_enable = mot_q;
   assign trip_active = trip_q;
   assign trip_code = code_q;
   assign ramping = ramp_q;
endmodule // spt_speed_pot

// [tb/spt_speed_pot_properties.sv]
// Property checker for the speed pot and thermistor trip block
module spt_speed_pot_properties #(
   parameter int NUM_INPUTS = 6,
   parameter int FREQ_W = 16,
   parameter int TIME_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Block inputs
   input wire logic [NUM_INPUTS-1:0] prog_inputs,
   input wire logic [NUM_INPUTS*spt_pkg::FUNC_W-1:0] input_func,
   input wire logic [15:0] thermistor_sense_input,
   input wire logic run_cmd,
   input wire logic jog_input,
   input wire logic trip_reset_input,
   input wire logic [1:0] freq_source,
   input wire logic second_set_sel,
   input wire logic [FREQ_W-1:0] std_freq_setting,
   input wire logic [FREQ_W-1:0] max_freq,
   input wire logic [TIME_W-1:0] first_accel_time,
   input wire logic [TIME_W-1:0] first_decel_time,
   input wire logic [TIME_W-1:0] second_accel_time,
   input wire logic [TIME_W-1:0] second_decel_time,
   // Block outputs
   input wire logic [FREQ_W-1:0] out_freq,
   input wire logic motor_enable,
   input wire logic trip_active,
   input wire logic [7:0] trip_code,
   input wire logic ramping
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic th_sel;
   assign th_sel = input_func[24:20] == spt_pkg::FUNC_THERM;
   a_hot_trips: assert property (
      th_sel && thermistor_sense_input > spt_pkg::THERM_TRIP_OHMS |=> trip_active)
      else $error("no trip when hot");
   a_open_trips: assert property (
      th_sel && thermistor_sense_input == spt_pkg::THERM_OPEN_OHMS |=> trip_active)
      else $error("no trip when open");
   a_trip_needs_sel: assert property (!trip_active && !th_sel |=> !trip_active)
      else $error("trip without sensor");
   a_trip_motor_off: assert property (
      trip_active |-> !motor_enable && trip_code == spt_pkg::TRIP_CODE_THERM)
      else $error("trip outputs wrong");
   a_jog_blocks: assert property (jog_input |=> !ramping)
      else $error("ramp during jog");
   a_src_gate: assert property (freq_source != spt_pkg::SRC_OPERATOR |=> !ramping)
      else $error("ramp with other source");
   a_run_gate: assert property (!run_cmd |=> !ramping)
      else $error("ramp without run");
   a_freq_limit: assert property (motor_enable |-> out_freq <= max_freq)
      else $error("frequency over limit");
   a_hold_frozen: assert property (
      !ramping && !$past(ramping) && run_cmd && $past(run_cmd, 2) && !trip_active
      && !$past(trip_active) && $past(max_freq) == $past(max_freq, 2)
      |-> $stable(out_freq)) else $error("frequency drifts");
   c_trip: cover property (trip_active);
   c_trip_clear: cover property ($fell(trip_active));
   c_ramp: cover property (ramping);
   c_at_max: cover property (motor_enable && out_freq == max_freq);
endmodule // spt_speed_pot_properties

// [tb/spt_contacts.sv]
// Switch contacts and winding thermistor model
module spt_contacts (
   // Clock
   input wire logic clk,
   // Commands
   input wire logic up,
   input wire logic dn,
   input wire logic [15:0] ohms,
   // Toward the block
   output logic [5:0] pins,
   output logic [15:0] th_ohms
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk) begin
      pins <= {dn, 4'h0, up};
      th_ohms <= ohms;
   end
endmodule // spt_contacts

// [tb/tb_top.sv]
// Top bench for the speed pot and thermistor trip block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, run_cmd = 0, jog_input = 0, trip_reset_input = 0;
   logic second_set_sel = 0, up = 0, dn = 0, look = 0, motor_enable, trip_active, ramping;
   logic [1:0] freq_source = 2'h2;
   logic [15:0] ohms = 16'h03E8, std_freq_setting = 16'h0001, max_freq = 16'h0003;
   logic [15:0] first_accel_time = 16'h0000, first_decel_time = 16'h00FF, thermistor_sense_input;
   logic [15:0] second_accel_time = 16'h00FF, second_decel_time = 16'h0000, out_freq;
   logic [29:0] input_func = {spt_pkg::FUNC_LOWER, spt_pkg::FUNC_THERM, 15'h0000,
      spt_pkg::FUNC_RAISE};
   logic [5:0] prog_inputs;
   logic [7:0] trip_code;
   logic [27:0] q[$];
   logic [27:0] e;
   logic [31:0] x = 32'hB51B;
   int failures = 0, tests_run = 0;
   initial forever #10 clk = ~clk;
   spt_contacts u_ct (.clk(clk), .up(up), .dn(dn), .ohms(ohms), .pins(prog_inputs),
      .th_ohms(thermistor_sense_input));
   spt_speed_pot dut (
      .clk(clk),
      .rst_n(rst_n),
      .prog_inputs(prog_inputs),
      .input_func(input_func),
      .thermistor_sense_input(thermistor_sense_input),
      .run_cmd(run_cmd),
      .jog_input(jog_input),
      .trip_reset_input(trip_reset_input),
      .freq_source(freq_source),
      .second_set_sel(second_set_sel),
      .std_freq_setting(std_freq_setting),
      .max_freq(max_freq),
      .first_accel_time(first_accel_time),
      .first_decel_time(first_decel_time),
      .second_accel_time(second_accel_time),
      .second_decel_time(second_decel_time),
      .out_freq(out_freq),
      .motor_enable(motor_enable),
      .trip_active(trip_active),
      .trip_code(trip_code),
      .ramping(ramping)
   );
   function automatic logic [31:0] xs(logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   task automatic wt(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(logic full, logic [26:0] ex);
      q.push_back({full, ex});
      look <= 1'b1;
      @(posedge clk);
      look <= 1'b0;
      $display("test step ended at %0t", $time);
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (look) begin
         e = q.pop_front();
         tests_run++;
         if (e[27] ? {trip_active, motor_enable, ramping, trip_code, out_freq} !== e[26:0]
               : {trip_active, motor_enable, ramping, trip_code} !== e[26:16]) begin
            failures++;
            $display("Error %0t: got %h", $time, {trip_active, motor_enable, ramping, trip_code,
               out_freq});
         end
      end
   end
   initial begin
      x = xs(x);
      wt(16);
      rst_n <= 1'b1;
      std_freq_setting <= {14'h0000, x[1:0]} + 16'h0001;
      max_freq <= {14'h0000, x[1:0]} + 16'h0003;
      run_cmd <= 1'b1;
      wt(3);
      chk(1, {3'b010, 8'h00, std_freq_setting});
      // Contact holds span more than one ramp tick of 5000 cycles, scaled down from the contact minimum
      up <= 1'b1;
      wt(3);
      chk(0, {3'b011, 8'h00, 16'h0000});
      wt(16000);
      up <= 1'b0;
      wt(3);
      chk(1, {3'b010, 8'h00, max_freq});
      wt(5500);
      chk(1, {3'b010, 8'h00, max_freq});
      second_set_sel <= 1'b1;
      up <= 1'b1;
      dn <= 1'b1;
      wt(5500);
      up <= 1'b0;
      jog_input <= 1'b1;
      wt(5500);
      dn <= 1'b0;
      wt(2);
      jog_input <= 1'b0;
      wt(3);
      chk(1, {3'b010, 8'h00, max_freq});
      dn <= 1'b1;
      wt(3);
      chk(0, {3'b011, 8'h00, 16'h0000});
      wt(36000);
      dn <= 1'b0;
      wt(3);
      chk(1, {3'b010, 8'h00, 16'h0000});
      // Thermistor code on another input is not honoured
      input_func <= {spt_pkg::FUNC_LOWER, 5'h00, 10'h000, spt_pkg::FUNC_THERM, spt_pkg::FUNC_RAISE};
      ohms <= 16'h0BB9;
      wt(4);
      chk(1, {3'b010, 8'h00, 16'h0000});
      input_func <= {spt_pkg::FUNC_LOWER, spt_pkg::FUNC_THERM, 15'h0000, spt_pkg::FUNC_RAISE};
      wt(4);
      chk(0, {3'b100, spt_pkg::TRIP_CODE_THERM, 16'h0000});
      ohms <= 16'h0BB8;
      trip_reset_input <= 1'b1;
      wt(3);
      trip_reset_input <= 1'b0;
      wt(4);
      chk(1, {3'b010, 8'h00, std_freq_setting});
      run_cmd <= 1'b0;
      up <= 1'b1;
      wt(5500);
      chk(1, {3'b000, 8'h00, std_freq_setting});
      run_cmd <= 1'b1;
      freq_source <= 2'h1;
      wt(5500);
      chk(1, {3'b010, 8'h00, std_freq_setting});
      up <= 1'b0;
      freq_source <= 2'h2;
      ohms <= 16'hFFFF;
      wt(4);
      chk(0, {3'b100, spt_pkg::TRIP_CODE_THERM, 16'h0000});
      summarize();
   end
endmodule // tb_top
bind spt_speed_pot spt_speed_pot_properties #(.NUM_INPUTS(NUM_INPUTS), .FREQ_W(FREQ_W),
   .TIME_W(TIME_W)) u_props (
   .clk(clk),
   .rst_n(rst_n),
   .prog_inputs(prog_inputs),
   .input_func(input_func),
   .thermistor_sense_input(thermistor_sense_input),
   .run_cmd(run_cmd),
   .jog_input(jog_input),
   .trip_reset_input(trip_reset_input),
   .freq_source(freq_source),
   .second_set_sel(second_set_sel),
   .std_freq_setting(std_freq_setting),
   .max_freq(max_freq),
   .first_accel_time(first_accel_time),
   .first_decel_time(first_decel_time),
   .second_accel_time(second_accel_time),
   .second_decel_time(second_decel_time),
   .out_freq(out_freq),
   .motor_enable(motor_enable),
   .trip_active(trip_active),
   .trip_code(trip_code),
   .ramping(ramping)
);
